// *** src/dram_ctl_pkg.sv ***
// Purpose: shared constants and types of the interleaved DRAM controller
// Assumes: 40 MHz system clock, word addressing on the link
// Notes: program word layout and host register map are listed here
package dram_ctl_pkg;

  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int WADDR_W = 20;
  localparam int MUX_W = 9;
  localparam int PROG_W = 16;
  localparam int REF_W = 8;

  // Timing, figures in ns and derived cycle counts (least times round up)
  localparam int CLK_NS = 25;
  localparam int PRECHARGE_NS = 50;
  localparam int REF_RAS_NS = 50;
  localparam int PRE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC = (REF_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] PRE_LOAD = 2'(PRE_CYC - 1);
  localparam logic [1:0] REF_LAST = 2'(REF_CYC - 1);

  // Memory device depth codes in the program word
  localparam logic [1:0] SIZE_16K = 2'h0;
  localparam logic [1:0] SIZE_64K = 2'h1;
  localparam logic [1:0] SIZE_256K = 2'h2;

  // Program word fields
  localparam int CFG_SIZE_LSB = 8;
  localparam int CFG_REF_LSB = 0;

  // Built-in sets: sync A, async B, fast cycle, 236-clock refresh, 256K
  localparam logic [PROG_W-1:0] DEFAULT_LOW_SET = 16'hBEEC;
  localparam logic [PROG_W-1:0] DEFAULT_HIGH_SET = 16'hAAEC;

  // Strap positions as captured after reset
  localparam int STRAP_A_SEL = 0;
  localparam int STRAP_B_SEL = 1;
  localparam int STRAP_SELF_REF = 2;

  // Host register map (APB byte addresses) and command bits
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CMD_GO = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_BHE = 2;
  localparam int CMD_REFRESH = 3;

  typedef enum logic [2:0] {
    ST_PROG,
    ST_IDLE,
    ST_PRE_WAIT,
    ST_ROW,
    ST_COL,
    ST_REF
  } ctl_state_t;

endpackage

// *** src/dram_link_if.sv ***
// Purpose: pins between the processor side and the DRAM controller
// Assumes: every signal is synchronous to clk_sys
// Notes: memory strobes are carried here so the byte marks can see them
`timescale 1ns/1ps
`default_nettype none
interface dram_link_if
  import dram_ctl_pkg::*;
;
  logic [BANKS-1:0] ras_n;
  logic [BANKS-1:0] cas_n;
  logic [MUX_W-1:0] dram_addr;
  logic dram_we_n;
  logic port_a_ack_n;
  logic program_clock;
  logic cmd_rd_n;
  logic cmd_wr_n;
  logic port_a_enable_n;
  logic [WADDR_W-1:0] addr;
  logic addr0;
  logic byte_high_enable_n;
  logic byte_we_hi_n;
  logic byte_we_lo_n;
  logic port_a_protocol_select;
  logic port_b_protocol_select;
  logic refresh_request_strap;
  logic port_b_enable_n;
  logic port_b_req_n;
  logic refresh_req_n;
  logic program_serial_input;

  modport ctl (
    output ras_n, cas_n, dram_addr, dram_we_n, port_a_ack_n,
    output program_clock,
    input cmd_rd_n, cmd_wr_n, port_a_enable_n, addr,
    input port_a_protocol_select, port_b_protocol_select,
    input refresh_request_strap, port_b_enable_n, port_b_req_n,
    input refresh_req_n, program_serial_input
  );

  modport cpu (
    input ras_n, cas_n, dram_addr, dram_we_n, port_a_ack_n,
    input program_clock,
    output cmd_rd_n, cmd_wr_n, port_a_enable_n, addr, addr0,
    output byte_high_enable_n, byte_we_hi_n, byte_we_lo_n,
    output port_a_protocol_select, port_b_protocol_select,
    output refresh_request_strap, port_b_enable_n, port_b_req_n,
    output refresh_req_n, program_serial_input
  );
endinterface
`default_nettype wire

// *** src/interleaved_dram_controller.sv ***
// Purpose: four-bank interleaved DRAM controller, port A and refresh
// Assumes: port A synchronous to clk_sys; program word shifted in at start
// Notes: port B service and error correction are not built
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module interleaved_dram_controller
  import dram_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  dram_link_if.ctl lnk,
  output logic [PROG_W-1:0] config_word,
  output logic [2:0] strap_state,
  output logic config_done,
  output logic port_b_pending
);

  typedef struct packed {
    ctl_state_t st;
    logic a_pend;
    logic served;
    logic stb_prev;
    logic wr;
    logic [WADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic [BANK_W-1:0] last_bank;
    logic last_valid;
    logic all_pre;
    logic [1:0] pre_cnt;
    logic [1:0] phase;
    logic [BANKS-1:0] ras_n;
    logic [BANKS-1:0] cas_n;
    logic [MUX_W-1:0] dram_addr;
    logic we_n;
    logic ack_n;
    logic ref_pend;
    logic [REF_W-1:0] ref_timer;
    logic [MUX_W-1:0] ref_row;
    logic pclk;
    logic [4:0] bit_cnt;
    logic [PROG_W-1:0] shift;
    logic [PROG_W-1:0] cfg;
    logic [2:0] straps;
    logic pb_pend;
    logic cfg_done;
  } ctl_regs_t;

  localparam ctl_regs_t CTL_RESET = '{
    st: ST_PROG,
    stb_prev: 1'b0,
    ras_n: '1,
    cas_n: '1,
    we_n: 1'b1,
    ack_n: 1'b1,
    default: '0
  };

  ctl_regs_t state_r;
  ctl_regs_t state_nxt;

  // Address half for the selected device depth
  function automatic logic [MUX_W-1:0] mux_half(
    input logic [1:0] size,
    input logic [WADDR_W-1:0] a,
    input logic col
  );
    logic [WADDR_W-1:0] s;
    s = a >> BANK_W;
    case (size)
      SIZE_16K: mux_half = col ? {2'h0, s[13:7]} : {2'h0, s[6:0]};
      SIZE_64K: mux_half = col ? {1'h0, s[15:8]} : {1'h0, s[7:0]};
      default: mux_half = col ? s[17:9] : s[8:0];
    endcase
  endfunction

  always_comb
  begin
    logic stb_low;
    logic cs;
    logic cmd_mode;
    logic new_req;
    logic [WADDR_W-1:0] tgt;
    logic tgt_wr;
    logic [BANK_W-1:0] tb;
    logic [1:0] size;
    logic [PROG_W-1:0] word;
    stb_low = ~lnk.cmd_rd_n | ~lnk.cmd_wr_n;
    cs = ~lnk.port_a_enable_n;
    cmd_mode = ~state_r.straps[STRAP_A_SEL];
    new_req = 1'b0;
    tgt = state_r.addr;
    tgt_wr = state_r.wr;
    tb = '0;
    size = state_r.cfg[CFG_SIZE_LSB +: 2];
    word = {state_r.shift[PROG_W-2:0], lnk.program_serial_input};
    state_nxt = state_r;

    if (state_r.pre_cnt != 2'h0)
      state_nxt.pre_cnt = state_r.pre_cnt - 2'h1;

    // Port A request capture
    if (state_r.cfg_done)
    begin
      state_nxt.stb_prev = stb_low;
      if (!stb_low)
        state_nxt.served = 1'b0;
      if (cmd_mode)
        new_req = cs & stb_low & ~state_r.stb_prev;
      else
        new_req = cs & stb_low & ~state_r.served;
      if (new_req && !state_r.a_pend)
      begin
        state_nxt.served = 1'b1;
        state_nxt.a_pend = 1'b1;
        state_nxt.addr = lnk.addr;
        state_nxt.wr = ~lnk.cmd_wr_n;
        tgt = lnk.addr;
        tgt_wr = ~lnk.cmd_wr_n;
      end
    end
    tb = tgt[BANK_W-1:0];

    unique case (state_r.st)
      ST_PROG:
      begin
        state_nxt.pclk = ~state_r.pclk;
        if (state_r.bit_cnt == 5'h0 && !state_r.pclk)
          state_nxt.straps = {lnk.refresh_request_strap,
                              lnk.port_b_protocol_select,
                              lnk.port_a_protocol_select};
        if (state_r.pclk)
        begin
          state_nxt.shift = word;
          state_nxt.bit_cnt = state_r.bit_cnt + 5'h1;
          if (state_r.bit_cnt == 5'(PROG_W - 1))
          begin
            if (word == '0)
              state_nxt.cfg = DEFAULT_LOW_SET;
            else if (word == '1)
              state_nxt.cfg = DEFAULT_HIGH_SET;
            else
              state_nxt.cfg = word;
            state_nxt.ref_timer = state_nxt.cfg[CFG_REF_LSB +: REF_W];
            state_nxt.pclk = 1'b0;
            state_nxt.cfg_done = 1'b1;
            state_nxt.st = ST_IDLE;
          end
        end
      end
      ST_IDLE:
      begin
        if (state_r.ref_pend && state_r.pre_cnt == 2'h0)
        begin
          state_nxt.ref_pend = 1'b0;
          state_nxt.ras_n = '0;
          state_nxt.dram_addr = state_r.ref_row;
          state_nxt.phase = 2'h0;
          state_nxt.st = ST_REF;
        end
        else if (state_r.a_pend || new_req)
        begin
          state_nxt.a_pend = 1'b0;
          state_nxt.bank = tb;
          if (state_r.last_valid && state_r.pre_cnt != 2'h0 &&
              (state_r.all_pre || state_r.last_bank == tb))
            state_nxt.st = ST_PRE_WAIT;
          else
          begin
            state_nxt.ras_n[tb] = 1'b0;
            state_nxt.dram_addr = mux_half(size, tgt, 1'b0);
            state_nxt.we_n = ~tgt_wr;
            state_nxt.st = ST_ROW;
          end
        end
      end
      ST_PRE_WAIT:
      begin
        if (state_r.pre_cnt == 2'h0)
        begin
          state_nxt.ras_n[state_r.bank] = 1'b0;
          state_nxt.dram_addr = mux_half(size, state_r.addr, 1'b0);
          state_nxt.we_n = ~state_r.wr;
          state_nxt.st = ST_ROW;
        end
      end
      ST_ROW:
      begin
        state_nxt.cas_n[state_r.bank] = 1'b0;
        state_nxt.dram_addr = mux_half(size, state_r.addr, 1'b1);
        state_nxt.ack_n = 1'b0;
        state_nxt.st = ST_COL;
      end
      ST_COL:
      begin
        state_nxt.ras_n = '1;
        state_nxt.cas_n = '1;
        state_nxt.we_n = 1'b1;
        state_nxt.ack_n = 1'b1;
        state_nxt.last_bank = state_r.bank;
        state_nxt.last_valid = 1'b1;
        state_nxt.all_pre = 1'b0;
        state_nxt.pre_cnt = PRE_LOAD;
        state_nxt.st = ST_IDLE;
      end
      ST_REF:
      begin
        state_nxt.phase = state_r.phase + 2'h1;
        if (state_r.phase == REF_LAST)
        begin
          state_nxt.ras_n = '1;
          state_nxt.ref_row = state_r.ref_row + 9'h001;
          state_nxt.last_valid = 1'b1;
          state_nxt.all_pre = 1'b1;
          state_nxt.pre_cnt = PRE_LOAD;
          state_nxt.st = ST_IDLE;
        end
      end
    endcase

    // Refresh sources; a new request wins over the clear above
    if (state_r.cfg_done)
    begin
      if (state_r.straps[STRAP_SELF_REF])
      begin
        if (state_r.ref_timer == '0)
        begin
          state_nxt.ref_timer = state_r.cfg[CFG_REF_LSB +: REF_W];
          state_nxt.ref_pend = 1'b1;
        end
        else
          state_nxt.ref_timer = state_r.ref_timer - 8'h01;
      end
      else if (!lnk.refresh_req_n)
        state_nxt.ref_pend = 1'b1;
      if (!lnk.port_b_enable_n && !lnk.port_b_req_n)
        state_nxt.pb_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state_r <= CTL_RESET;
    else
      state_r <= state_nxt;
  end

  assign lnk.ras_n = state_r.ras_n;
  assign lnk.cas_n = state_r.cas_n;
  assign lnk.dram_addr = state_r.dram_addr;
  assign lnk.dram_we_n = state_r.we_n;
  assign lnk.port_a_ack_n = state_r.ack_n;
  assign lnk.program_clock = state_r.pclk;
  assign config_word = state_r.cfg;
  assign strap_state = state_r.straps;
  assign config_done = state_r.cfg_done;
  assign port_b_pending = state_r.pb_pend;

endmodule
`default_nettype wire

// *** src/cpu_side_end.sv ***
// Purpose: processor-side end: bus cycles, byte marks, program register
// Assumes: software orders cycles over APB; one cycle in flight at a time
// Notes: program word and straps are fixed by parameters
`timescale 1ns/1ps
`default_nettype none
module cpu_side_end
  import dram_ctl_pkg::*;
#(
  parameter logic [PROG_W-1:0] PROG_WORD = 16'h0000,
  parameter logic STRAP_A_SEL_LVL = 1'b0,
  parameter logic STRAP_B_SEL_LVL = 1'b1,
  parameter logic STRAP_SELF_REF_LVL = 1'b1,
  parameter logic PORT_B_EN_N_LVL = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic srst,
  dram_link_if.cpu lnk,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef struct packed {
    logic [PROG_W-1:0] shreg;
    logic busy;
    logic wr;
    logic byte_high_enable;
    logic [WADDR_W:0] addr;
    logic ref_req;
    logic [7:0] wait_cnt;
    logic [7:0] last_wait;
    logic [31:0] rdata;
  } cpu_regs_t;

  localparam cpu_regs_t CPU_RESET = '{shreg: PROG_WORD, default: '0};

  cpu_regs_t state_r;
  cpu_regs_t state_nxt;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == REG_CMD) || (a == REG_ADDR) || (a == REG_STATUS);
  endfunction

  always_comb
  begin
    logic sync_ready_input;
    logic wr_acc;
    sync_ready_input = ~lnk.port_a_ack_n;
    wr_acc = psel & penable & pwrite;
    state_nxt = state_r;
    state_nxt.ref_req = 1'b0;

    if (lnk.program_clock)
      state_nxt.shreg = {state_r.shreg[PROG_W-2:0], 1'b0};

    if (state_r.busy)
    begin
      if (sync_ready_input)
      begin
        state_nxt.busy = 1'b0;
        state_nxt.last_wait = state_r.wait_cnt;
      end
      else
        state_nxt.wait_cnt = state_r.wait_cnt + 8'h01;
    end

    if (psel && !penable)
    begin
      state_nxt.rdata = 32'h0000_0000;
      if (paddr == REG_CMD)
        state_nxt.rdata = {29'h0, state_r.byte_high_enable, state_r.wr, state_r.busy};
      else if (paddr == REG_ADDR)
        state_nxt.rdata = {11'h0, state_r.addr};
      else if (paddr == REG_STATUS)
        state_nxt.rdata = {16'h0, state_r.last_wait, 7'h0, state_r.busy};
    end

    if (wr_acc && paddr == REG_ADDR && !state_r.busy)
      state_nxt.addr = pwdata[WADDR_W:0];
    if (wr_acc && paddr == REG_CMD)
    begin
      state_nxt.ref_req = pwdata[CMD_REFRESH];
      // The ack edge may start the next cycle at once
      if (pwdata[CMD_GO] && (!state_r.busy || sync_ready_input))
      begin
        state_nxt.busy = 1'b1;
        state_nxt.wr = pwdata[CMD_WRITE];
        state_nxt.byte_high_enable = pwdata[CMD_BHE];
        state_nxt.wait_cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state_r <= CPU_RESET;
    else
      state_r <= state_nxt;
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~reg_hit(paddr);
  assign prdata = state_r.rdata;

  // Strobe lifts in the ack cycle so a chained cycle has a fresh edge
  assign lnk.cmd_rd_n =
    ~(state_r.busy & ~state_r.wr & lnk.port_a_ack_n);
  assign lnk.cmd_wr_n =
    ~(state_r.busy & state_r.wr & lnk.port_a_ack_n);
  assign lnk.port_a_enable_n = ~state_r.busy;
  assign lnk.addr = state_r.addr[WADDR_W:1];
  assign lnk.addr0 = state_r.addr[0];
  assign lnk.byte_high_enable_n = ~state_r.byte_high_enable;
  // Write enable reaches the low half when addr0 is low, the high half when byte high enable is set
  assign lnk.byte_we_lo_n = lnk.dram_we_n | state_r.addr[0];
  assign lnk.byte_we_hi_n = lnk.dram_we_n | ~state_r.byte_high_enable;
  assign lnk.port_a_protocol_select = STRAP_A_SEL_LVL;
  assign lnk.port_b_protocol_select = STRAP_B_SEL_LVL;
  assign lnk.refresh_request_strap = STRAP_SELF_REF_LVL;
  assign lnk.port_b_enable_n = PORT_B_EN_N_LVL;
  assign lnk.port_b_req_n = 1'b1;
  assign lnk.refresh_req_n = ~state_r.ref_req;
  assign lnk.program_serial_input = state_r.shreg[PROG_W-1];

endmodule
`default_nettype wire

// *** tb/dram_ctl_assertions.sv ***
// Purpose: concurrent checks on the processor to controller link
// Assumes: default program word, so the 256K row and column split
// Notes: instanced beside the link by the bench, no bind
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_assertions
  import dram_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [BANKS-1:0] ras_n,
  input wire logic [BANKS-1:0] cas_n,
  input wire logic [MUX_W-1:0] dram_addr,
  input wire logic dram_we_n,
  input wire logic port_a_ack_n,
  input wire logic program_clock,
  input wire logic cmd_rd_n,
  input wire logic cmd_wr_n,
  input wire logic port_a_enable_n,
  input wire logic [WADDR_W-1:0] addr,
  input wire logic addr0,
  input wire logic byte_high_enable_n,
  input wire logic byte_we_hi_n,
  input wire logic byte_we_lo_n,
  input wire logic port_b_enable_n,
  input wire logic port_b_pending,
  input wire logic config_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_row_bank_addr: assert property (
    ($past(ras_n) == 4'hF && ras_n != 4'hF && ras_n != 4'h0) |->
    (ras_n == ~(4'h1 << addr[1:0]) && dram_addr == addr[10:2]))
    else $error("row strobe bank or row address wrong");
  a_col_addr: assert property (
    ($past(cas_n) == 4'hF && cas_n != 4'hF) |->
    (cas_n == ras_n && dram_addr == addr[19:11]))
    else $error("column strobe bank or column address wrong");
  a_cas_under_ras: assert property (
    ((~cas_n) & ras_n) == 4'h0)
    else $error("column strobe without row strobe");
  a_ras_precharge: assert property (
    ((~ras_n) & $past(ras_n) & ~$past(ras_n, 2)) == 4'h0)
    else $error("row strobe high for less than two cycles");
  // Window allows a refresh to go first
  a_ack_latency: assert property (
    ($fell(cmd_rd_n & cmd_wr_n) && !port_a_enable_n) |->
    ##[2:7] !port_a_ack_n)
    else $error("acknowledge missing after request");
  a_ack_pulse: assert property (
    !port_a_ack_n |-> (cas_n != 4'hF) ##1 port_a_ack_n)
    else $error("acknowledge not a single cycle in column phase");
  a_refresh_len: assert property (
    (ras_n == 4'h0 && $past(ras_n) != 4'h0) |=>
    ras_n == 4'h0 ##1 ras_n == 4'hF)
    else $error("refresh row strobe not two cycles");
  a_byte_marks: assert property (
    byte_we_hi_n == (dram_we_n | byte_high_enable_n) &&
    byte_we_lo_n == (dram_we_n | addr0))
    else $error("byte write enables wrong");
  a_write_window: assert property (
    !dram_we_n |-> ((!cmd_wr_n || !port_a_ack_n) && ras_n != 4'hF))
    else $error("write enable outside a write cycle");
  a_port_b_quiet: assert property (
    port_b_enable_n |-> !port_b_pending)
    else $error("port b activity taken while disabled");
  a_prog_clk_stop: assert property (
    config_done |-> !program_clock)
    else $error("program clock running after programming");
endmodule
`default_nettype wire

// *** tb/tb_interleaved_dram_controller.sv ***
// Purpose: self-checking bench for both ends of the DRAM link
// Assumes: default straps and program word of the processor end
// Notes: cycles are ordered over APB; one access in flight
`timescale 1ns/1ps
`default_nettype none
module tb_interleaved_dram_controller
  import dram_ctl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr;
  logic psel, penable, pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [PROG_W-1:0] config_word;
  logic [2:0] strap_state;
  logic config_done, port_b_pending;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  dram_link_if lnk();
  interleaved_dram_controller u_interleaved_dram_controller (
    .clk_sys(clk_sys), .srst(srst), .lnk(lnk), .config_word(config_word),
    .strap_state(strap_state), .config_done(config_done),
    .port_b_pending(port_b_pending));
  cpu_side_end u_cpu_side_end (
    .clk_sys(clk_sys), .srst(srst), .lnk(lnk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dram_ctl_assertions u_dram_ctl_assertions (
    .clk_sys(clk_sys), .srst(srst), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
    .dram_addr(lnk.dram_addr), .dram_we_n(lnk.dram_we_n),
    .port_a_ack_n(lnk.port_a_ack_n), .program_clock(lnk.program_clock),
    .cmd_rd_n(lnk.cmd_rd_n), .cmd_wr_n(lnk.cmd_wr_n),
    .port_a_enable_n(lnk.port_a_enable_n), .addr(lnk.addr),
    .addr0(lnk.addr0), .byte_high_enable_n(lnk.byte_high_enable_n),
    .byte_we_hi_n(lnk.byte_we_hi_n), .byte_we_lo_n(lnk.byte_we_lo_n),
    .port_b_enable_n(lnk.port_b_enable_n), .port_b_pending(port_b_pending),
    .config_done(config_done));

  initial forever #12.5 clk_sys = ~clk_sys;

  task finish_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check_word(input string what, input logic [31:0] exp,
                  input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, read data and error taken at the ready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do
      @(posedge clk_sys);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wait_idle;
    do
      apb(1'h0, REG_STATUS, 32'h0);
    while (rd[0] !== 1'h0);
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'h0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      if (lnk.program_clock === 1'h1)
        n++;
    end
    while (config_done !== 1'h1);
    check_word("program clocks", PROG_W, n);
    check_word("config word", DEFAULT_LOW_SET, config_word);
    check_word("straps", 3'h6, strap_state);
    check_word("port b pending", 1'h0, port_b_pending);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (lnk.ras_n !== 4'h0 && n < 300);
    check_word("self refresh", 4'h0, lnk.ras_n);
    repeat (8) @(posedge clk_sys);
    // Consecutive words walk all banks, reads and writes; only the high byte gets written
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, REG_ADDR, {11'h0, 20'h5A5A4 + 20'(i), i[0]});
      apb(1'h1, REG_CMD, {29'h0, i[1], i[0], 1'h1});
      wait_idle();
      check_word("access cycles", 8'h02, rd[15:8]);
    end
    apb(1'h0, REG_CMD, 32'h0);
    check_word("command readback", 3'h6, rd[2:0]);
    apb(1'h0, 8'h0C, 32'h0);
    check_word("unmapped read error", 1'h1, err);
    check_word("unmapped read data", 32'h0, rd);
    apb(1'h1, 8'h10, 32'hFFFFFFFF);
    check_word("unmapped write error", 1'h1, err);
    // Same bank chained at the ack edge: one wait state
    apb(1'h1, REG_CMD, 32'h0000_0001);
    apb(1'h1, REG_CMD, 32'h0000_0003);
    wait_idle();
    check_word("same bank cycles", 8'h03, rd[15:8]);
    finish_test();
  end
endmodule
`default_nettype wire
